// ### hdl/gdf_pkg.sv
package gdf_pkg;
  localparam int CLK_HZ = 100_000_000;
  // acknowledge pulse length, ns
  localparam int ACK_NS = 900;
  localparam int ACK_CYC = (ACK_NS * (CLK_HZ / 1_000_000)) / 1000;
  // failure indication, ms
  localparam int FAIL_MS = 1000;
  localparam int FAIL_CYC = FAIL_MS * (CLK_HZ / 1000);
  // latest turn-off after short circuit, ns
  localparam int SC_OFF_NS = 10_000;
  localparam int SC_OFF_CYC = (SC_OFF_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int CNT_W = 27;
  localparam logic GATE_OFF_RST = 1'b0;
  localparam logic STATUS_RST = 1'b0;
  typedef enum logic {GDF_MODE_TWO_LEVEL, GDF_MODE_MULTI_LEVEL} gdf_mode_t;
endpackage : gdf_pkg

// ### hdl/gdf_if.sv
`timescale 1ns/1ps
interface gdf_if;
  logic start;
  logic [26:0] load;
  logic busy;
  modport ctrl (output start, output load, input busy);
  modport tmr (input start, input load, output busy);
endinterface : gdf_if

// ### hdl/gdf_timer.sv
`timescale 1ns/1ps
module gdf_timer (
  input wire logic clk,
  input wire logic rst_n,
  gdf_if.tmr t
);
  logic [26:0] cnt_reg;
  logic [26:0] cnt_next;
  assign cnt_next = t.start ? t.load :
                    (cnt_reg != 27'h0) ? cnt_reg - 27'h1 : 27'h0;
  assign t.busy = (cnt_reg != 27'h0);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= 27'h0;
    else
      cnt_reg <= cnt_next;
  end
endmodule : gdf_timer

// ### hdl/gdf_fault_status.sv
`timescale 1ns/1ps
module gdf_fault_status (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CMD_LIGHT,
  input wire logic SHORT_DETECT,
  input wire logic SUPPLY_OK,
  input wire logic FAULT_MODE_SELECT,
  output logic GATE_ON,
  output logic STATUS_LIGHT,
  output logic FAULT_LOCKED
);
  typedef enum logic [1:0] {GDF_RUN, GDF_LOCK} gdf_state_t;
  gdf_state_t state_reg, state_next;
  logic cmd_reg;
  logic ack_busy_reg;
  logic [9:0] ack_cnt_reg;
  logic cmd_edge;
  logic two_level;
  logic sc_event;
  logic lock_done;
  logic gate_next;
  logic status_next;
  logic ack_start;
  logic quiet_clear;
  logic [7:0] quiet_reg;
  logic [7:0] quiet_next;
  logic [7:0] edge_age_reg;
  logic [7:0] edge_age_next;
  logic [gdf_pkg::CNT_W-1:0] lock_cnt_reg;
  logic [gdf_pkg::CNT_W-1:0] lock_cnt_next;
  gdf_if tif ();
  gdf_timer u_timer (.clk(CLK), .rst_n(RESETN), .t(tif));

  // low selects positions 1-2
  assign two_level = (FAULT_MODE_SELECT ==
                      gdf_pkg::GDF_MODE_TWO_LEVEL);
  assign cmd_edge = CMD_LIGHT ^ cmd_reg;
  assign sc_event = SHORT_DETECT && (state_reg == GDF_RUN);
  assign lock_done = (state_reg == GDF_LOCK) && !tif.busy && !tif.start;
  assign tif.start = sc_event;
  assign tif.load = 27'(gdf_pkg::FAIL_CYC);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      GDF_RUN:
        if (sc_event)
          state_next = GDF_LOCK;
      GDF_LOCK:
        if (lock_done)
          state_next = GDF_RUN;
      default:
        state_next = GDF_RUN;
    endcase
  end

  // two-level: off immediately and held off while locked
  assign gate_next = CMD_LIGHT && SUPPLY_OK &&
                     !(two_level && (sc_event ||
                       state_next == GDF_LOCK));
  // dark on lock, supply fault or acknowledge
  assign status_next = SUPPLY_OK &&
                       (state_next == GDF_RUN) &&
                       !cmd_edge && !ack_busy_reg;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_reg <= GDF_RUN;
      cmd_reg <= 1'b0;
      ack_busy_reg <= 1'b0;
      ack_cnt_reg <= 10'h0;
      GATE_ON <= gdf_pkg::GATE_OFF_RST;
      STATUS_LIGHT <= gdf_pkg::STATUS_RST;
      FAULT_LOCKED <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cmd_reg <= CMD_LIGHT;
      if (cmd_edge && state_next == GDF_RUN)
      begin
        ack_busy_reg <= 1'b1;
        ack_cnt_reg <= 10'(gdf_pkg::ACK_CYC - 2);
      end
      else if (ack_cnt_reg != 10'h0)
        ack_cnt_reg <= ack_cnt_reg - 10'h1;
      else
        ack_busy_reg <= 1'b0;
      GATE_ON <= gate_next;
      STATUS_LIGHT <= status_next;
      FAULT_LOCKED <= (state_next == GDF_LOCK);
    end
  end

  // checker helpers only: nothing below feeds the outputs
  assign ack_start = cmd_edge && (state_next == GDF_RUN);
  // cycles of steady command, good supply and no fault
  assign quiet_clear = cmd_edge || !SUPPLY_OK || FAULT_LOCKED ||
                       SHORT_DETECT;
  assign quiet_next = quiet_clear ? 8'h0 :
                      (quiet_reg == 8'hff) ? quiet_reg :
                      quiet_reg + 8'h1;
  // cycles since the last acknowledged command edge
  assign edge_age_next = ack_start ? 8'h0 :
                         (edge_age_reg == 8'hff) ? edge_age_reg :
                         edge_age_reg + 8'h1;
  // cycles spent in the failure indication
  assign lock_cnt_next = !FAULT_LOCKED ? 27'h0 :
                         (lock_cnt_reg == 27'h7ffffff) ? lock_cnt_reg :
                         lock_cnt_reg + 27'h1;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      quiet_reg <= 8'h0;
      edge_age_reg <= 8'hff;
      lock_cnt_reg <= 27'h0;
    end
    else
    begin
      quiet_reg <= quiet_next;
      edge_age_reg <= edge_age_next;
      lock_cnt_reg <= lock_cnt_next;
    end
  end

  a_two_level_off: assert property (@(posedge CLK) disable iff (!RESETN)
    SHORT_DETECT && two_level |=> !GATE_ON)
    else $error("gate not off after short in two-level");
  a_three_follow: assert property (@(posedge CLK) disable iff (!RESETN)
    !two_level && CMD_LIGHT && SUPPLY_OK |=> GATE_ON)
    else $error("gate not following command in three-level");
  a_lock_dark: assert property (@(posedge CLK) disable iff (!RESETN)
    $rose(FAULT_LOCKED) |-> !STATUS_LIGHT [*8])
    else $error("status lit during failure lock");
  a_ack_dark: assert property (@(posedge CLK) disable iff (!RESETN)
    cmd_edge && state_next == GDF_RUN |=> !STATUS_LIGHT [*8])
    else $error("acknowledge pulse too short");
  a_ack_end: assert property (@(posedge CLK) disable iff (!RESETN)
    quiet_reg >= 8'(gdf_pkg::ACK_CYC)
      |-> STATUS_LIGHT)
    else $error("status not lit after acknowledge");
  a_ack_span: assert property (@(posedge CLK) disable iff (!RESETN)
    edge_age_reg == 8'(gdf_pkg::ACK_CYC - 1)
      |-> !STATUS_LIGHT)
    else $error("acknowledge pulse ended early");
  a_supply_dark: assert property (@(posedge CLK) disable iff (!RESETN)
    !SUPPLY_OK |=> !STATUS_LIGHT && !GATE_ON)
    else $error("status lit with bad supply");
  a_gate_cmd: assert property (@(posedge CLK) disable iff (!RESETN)
    !CMD_LIGHT |=> !GATE_ON)
    else $error("gate on with dark command");
  a_sel_mode: assert property (@(posedge CLK) disable iff (!RESETN)
    FAULT_LOCKED && FAULT_MODE_SELECT && CMD_LIGHT && SUPPLY_OK
      |=> GATE_ON)
    else $error("multi-level selection ignored");
  a_lock_release: assert property (@(posedge CLK) disable iff (!RESETN)
    lock_done |=> !FAULT_LOCKED)
    else $error("lock not released");
  a_lock_start: assert property (@(posedge CLK) disable iff (!RESETN)
    SHORT_DETECT && !FAULT_LOCKED
      |=> FAULT_LOCKED && !STATUS_LIGHT)
    else $error("short not reported");
  a_lock_all_dark: assert property (@(posedge CLK) disable iff (!RESETN)
    FAULT_LOCKED
      |-> !STATUS_LIGHT)
    else $error("status lit while locked");
  a_lock_hold: assert property (@(posedge CLK) disable iff (!RESETN)
    FAULT_LOCKED && tif.busy
      |=> FAULT_LOCKED)
    else $error("lock released early");
  a_lock_length: assert property (@(posedge CLK) disable iff (!RESETN)
    $fell(FAULT_LOCKED)
      |-> lock_cnt_reg == 27'(gdf_pkg::FAIL_CYC + 1))
    else $error("failure indication length wrong");
  a_timer_armed: assert property (@(posedge CLK) disable iff (!RESETN)
    $rose(FAULT_LOCKED)
      |-> tif.busy)
    else $error("lock timer not started");
  a_no_relock: assert property (@(posedge CLK) disable iff (!RESETN)
    FAULT_LOCKED
      |-> !tif.start)
    else $error("lock timer restarted");
  a_two_lock_off: assert property (@(posedge CLK) disable iff (!RESETN)
    two_level && FAULT_LOCKED && !lock_done
      |=> !GATE_ON)
    else $error("gate on during two-level lock");
  a_gate_follow: assert property (@(posedge CLK) disable iff (!RESETN)
    CMD_LIGHT && SUPPLY_OK && !FAULT_LOCKED && !SHORT_DETECT
      |=> GATE_ON)
    else $error("gate not on with lit command");
  c_ack: cover property (@(posedge CLK) cmd_edge ##1 !STATUS_LIGHT);
  c_two_fault: cover property (@(posedge CLK) sc_event && two_level);
  c_multi_fault: cover property (@(posedge CLK) sc_event && !two_level);
  c_release: cover property (@(posedge CLK) lock_done);
  c_lock_edge: cover property (@(posedge CLK) FAULT_LOCKED && cmd_edge);
endmodule : gdf_fault_status

// ### verification/gdf_host_model.sv
`timescale 1ns/1ps
module gdf_host_model (
  input wire logic clk,
  input wire logic cmd_req,
  input wire logic status_light,
  output logic cmd_light,
  output int dark_len
);
  int run = 0;
  initial cmd_light = 1'b0;
  initial dark_len = 0;
  // host alone decides when to turn off
  always @(posedge clk) cmd_light <= cmd_req;
  // length of the last dark stretch on status
  always @(posedge clk)
  begin
    run <= status_light ? 0 : run + 1;
    if (status_light && run != 0) dark_len <= run;
  end
endmodule : gdf_host_model

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic CLK = 0, RESETN = 0, SHORT_DETECT = 0, SUPPLY_OK = 1;
  logic FAULT_MODE_SELECT = 0, cmd_req = 0;
  logic CMD_LIGHT, GATE_ON, STATUS_LIGHT, FAULT_LOCKED;
  int dark_len, err_count = 0, cmp_count = 0;
  gdf_host_model i_host (.clk(CLK), .cmd_req(cmd_req),
    .status_light(STATUS_LIGHT), .cmd_light(CMD_LIGHT), .dark_len(dark_len));
  gdf_fault_status i_dut (.CLK(CLK), .RESETN(RESETN), .CMD_LIGHT(CMD_LIGHT),
    .SHORT_DETECT(SHORT_DETECT), .SUPPLY_OK(SUPPLY_OK),
    .FAULT_MODE_SELECT(FAULT_MODE_SELECT), .GATE_ON(GATE_ON),
    .STATUS_LIGHT(STATUS_LIGHT), .FAULT_LOCKED(FAULT_LOCKED));
  initial forever #5 CLK = ~CLK;
  task check(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task step(int n);
    repeat (n) @(posedge CLK);
  endtask : step
  task settle;
    @(negedge CLK);
  endtask : settle
  task start(logic mode);
    @(posedge CLK);
    RESETN <= 1'b0;
    cmd_req <= 1'b0;
    FAULT_MODE_SELECT <= mode;
    SUPPLY_OK <= 1'b1;
    step(10);
    RESETN <= 1'b1;
    step(5);
    settle;
    check("status idle", STATUS_LIGHT, 1'b1);
    check("gate idle", GATE_ON, 1'b0);
  endtask : start
  task t_ack;
    start(1'b0);
    cmd_req <= 1'b1;
    step(3);
    settle;
    check("gate on", GATE_ON, 1'b1);
    check("ack dark", STATUS_LIGHT, 1'b0);
    step(100);
    settle;
    check("ack length", dark_len, gdf_pkg::ACK_CYC);
    check("relit", STATUS_LIGHT, 1'b1);
    cmd_req <= 1'b0;
    step(3);
    settle;
    check("gate off", GATE_ON, 1'b0);
    check("fall ack", STATUS_LIGHT, 1'b0);
  endtask : t_ack
  task t_supply;
    start(1'b0);
    cmd_req <= 1'b1;
    step(100);
    SUPPLY_OK <= 1'b0;
    step(3);
    settle;
    check("supply dark", STATUS_LIGHT, 1'b0);
    check("supply gate", GATE_ON, 1'b0);
  endtask : t_supply
  task t_short(logic mode);
    start(mode);
    cmd_req <= 1'b1;
    step(100);
    SHORT_DETECT <= 1'b1;
    step(1);
    SHORT_DETECT <= 1'b0;
    settle;
    check("locked", FAULT_LOCKED, 1'b1);
    check("fault dark", STATUS_LIGHT, 1'b0);
    check("fault gate", GATE_ON, mode);
    cmd_req <= 1'b0;
    step(100);
    settle;
    check("no ack", STATUS_LIGHT, 1'b0);
    check("host off", GATE_ON, 1'b0);
  endtask : t_short
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  initial
  begin
    #1ms err_count++;
    end_sim;
  end
  initial
  begin
    t_ack;
    t_supply;
    t_short(1'b0);
    t_short(1'b1);
    end_sim;
  end
endmodule : tb
